// ==== hw/vpw_bus_config_registers.sv ====
// Contract
// RULE1: quad diag mode keeps break and tx timeout at nominal time
// RULE2: software loads an adjusted divider itself when entering quad mode
// RULE3: software changes divider and quad bit in one single write
// RULE4: divider field 5:0 set so clock equals 1MHz times field plus one
// RULE5: clock below 1MHz or not a multiple: software keeps block disabled
// RULE6: divider change may lose bus sync; change only while idle
// RULE7: control register reads back the last written value; code reads enable back as zero after a write that sets freeze or leaves freeze
// RULE8: enable low holds tx output passive and ignores rx input
// RULE9: clearing enable aborts every queued transmit request
// RULE10: enable cleared by reset, write of zero, and freeze becoming set
// RULE11: software clears freeze and sets enable in separate writes
// RULE12: freeze stops decoding; clearing restarts machines as after reset
// RULE13: freeze holds status, error, mask and priority bits at reset
// RULE14: length check on: over 12 bytes flags invalid frame, sleep until eof
// RULE15: length check off: no byte limit; cleared by reset
// RULE16: five-bit loop delay field selects delay in whole microseconds
// RULE17: physical address supplies the type 1 and 2 response byte
// RULE18: clock divided by field plus one gives the microsecond tick
`timescale 1ns/10ps
`include "vpw_cfg_defines.svh"
module vpw_bus_config_registers (
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bus_rx_in,
	output logic bus_tx_out,
	input wire logic engine_tx_level,
	input wire logic break_req,
	input wire logic rx_sof,
	input wire logic rx_bit,
	input wire logic rx_byte_done,
	input wire logic rx_eof_min,
	output logic rx_filtered,
	output logic us_tick,
	output logic engine_reset,
	output logic status_hold,
	output logic queue_abort,
	output logic invalid_frame_flag,
	output logic rx_sleep,
	output logic tx_timeout,
	output logic break_active,
	output logic [4:0] loop_delay_sel,
	output logic [7:0] ifr_address_byte,
	output logic quad_speed_diag
);
	localparam logic [`ADDR_W-1:0] A_PS = `ADDR_W'({`IDX_PRESCALE_SELECT, 2'b00});
	localparam logic [`ADDR_W-1:0] A_CTL = `ADDR_W'({`IDX_BLOCK_CONTROL, 2'b00});
	localparam logic [`ADDR_W-1:0] A_PA = `ADDR_W'({`IDX_NODE_PHYSICAL_ADDRESS, 2'b00});

	logic [7:0] prescale_select_ff;
	logic [7:0] nxt_prescale_select;
	logic [7:0] block_control_ff;
	logic [7:0] nxt_block_control;
	logic [7:0] node_physical_address_ff;
	logic [7:0] nxt_node_physical_address;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic pslverr_ff;
	logic nxt_pslverr;
	logic access;
	logic wr;
	logic hit_ps;
	logic hit_ctl;
	logic hit_pa;
	logic [7:0] wbyte;

	logic block_enable;
	logic clock_freeze;
	logic length_check_off;
	logic running;

	logic rx_meta_ff;
	logic rx_sync_ff;

	vpw_cfg_pkg::tx_state_t tx_state_ff;
	vpw_cfg_pkg::tx_state_t nxt_tx_state;
	logic [`TICK_CNT_W-1:0] brk_cnt_ff;
	logic [`TICK_CNT_W-1:0] nxt_brk_cnt;
	logic [`TICK_CNT_W-1:0] brk_limit;
	logic tto_trip;

	logic [`FRAME_CNT_W-1:0] frame_cnt_ff;
	logic [`FRAME_CNT_W-1:0] nxt_frame_cnt;
	logic ifd_ff;
	logic nxt_ifd;
	logic queue_abort_ff;
	logic nxt_queue_abort;

	tick_if tk ();

	// bus decode: zero-wait slave
	assign access = psel & penable;
	assign wr = access & pwrite;
	assign wbyte = pwdata[7:0];
	always_comb begin
		hit_ps = 1'b0;
		hit_ctl = 1'b0;
		hit_pa = 1'b0;
		if (paddr == A_PS) begin
			hit_ps = 1'b1;
		end else if (paddr == A_CTL) begin
			hit_ctl = 1'b1;
		end else if (paddr == A_PA) begin
			hit_pa = 1'b1;
		end
	end

	always_comb begin
		nxt_prescale_select = prescale_select_ff;
		nxt_block_control = block_control_ff;
		nxt_node_physical_address = node_physical_address_ff;
		if (wr && hit_ps) begin
			// divider and quad bit land together in one write [RULE3]
			nxt_prescale_select = wbyte & `PS_WRITE_MASK;
		end
		if (wr && hit_ctl) begin
			nxt_block_control = wbyte; // [RULE7] [RULE10]
			if (wbyte[`CTL_FREEZE_BIT]) begin
				// freeze forces enable low [RULE10]
				nxt_block_control[`CTL_ENABLE_BIT] = 1'b0;
			end else if (clock_freeze) begin
				// leaving freeze: enable needs a later write [RULE11]
				nxt_block_control[`CTL_ENABLE_BIT] = 1'b0;
			end
		end
		if (wr && hit_pa) begin
			nxt_node_physical_address = wbyte; // [RULE17]
		end
	end

	always_comb begin
		nxt_prdata = 32'h0000_0000;
		nxt_pslverr = 1'b0;
		if (psel && !penable) begin
			if (hit_ps) begin
				nxt_prdata = {24'h00_0000, prescale_select_ff};
			end else if (hit_ctl) begin
				nxt_prdata = {24'h00_0000, block_control_ff}; // [RULE7]
			end else if (hit_pa) begin
				nxt_prdata = {24'h00_0000, node_physical_address_ff};
			end else begin
				nxt_pslverr = 1'b1;
			end
		end else if (access) begin
			nxt_prdata = prdata_ff;
			nxt_pslverr = pslverr_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			prescale_select_ff <= `RST_PRESCALE_SELECT;
			block_control_ff <= `RST_BLOCK_CONTROL; // [RULE10] [RULE12] [RULE15]
			node_physical_address_ff <= `RST_NODE_PHYSICAL_ADDRESS;
			prdata_ff <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else begin
			prescale_select_ff <= nxt_prescale_select;
			block_control_ff <= nxt_block_control;
			node_physical_address_ff <= nxt_node_physical_address;
			prdata_ff <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
		end
	end

	assign prdata = prdata_ff;
	assign pready = 1'b1;
	assign pslverr = access & pslverr_ff;

	assign block_enable = block_control_ff[`CTL_ENABLE_BIT];
	assign clock_freeze = block_control_ff[`CTL_FREEZE_BIT];
	assign length_check_off = block_control_ff[`CTL_LENCHK_OFF_BIT];
	assign running = block_enable & ~clock_freeze;
	assign quad_speed_diag = prescale_select_ff[`PS_QUAD_BIT];
	assign loop_delay_sel = block_control_ff[`CTL_DELAY_HI:`CTL_DELAY_LO]; // [RULE16]
	assign ifr_address_byte = node_physical_address_ff; // [RULE17]
	assign engine_reset = srst | clock_freeze; // [RULE12]
	assign status_hold = clock_freeze; // [RULE13]

	// a divider write restarts the tick so a bad phase is not kept [RULE6]
	assign tk.quad = quad_speed_diag;
	assign tk.restart = (wr & hit_ps) | clock_freeze;
	assign us_tick = tk.us_tick;

	us_prescaler u_prescaler (
		.clk(clk),
		.srst(srst),
		.div_sel(prescale_select_ff[`PS_DIV_HI:`PS_DIV_LO]), // [RULE18] [RULE4]
		.tk(tk)
	);

	tx_timeout_guard u_tto (
		.clk(clk),
		.srst(srst | ~running),
		.active(bus_tx_out),
		.tk(tk),
		.tripped(tto_trip)
	);

	// receive pin crosses into clk domain
	always_ff @(posedge clk) begin
		if (srst) begin
			rx_meta_ff <= 1'b0;
			rx_sync_ff <= 1'b0;
		end else begin
			rx_meta_ff <= bus_rx_in;
			rx_sync_ff <= rx_meta_ff;
		end
	end
	assign rx_filtered = running & rx_sync_ff; // [RULE8] [RULE12]

	// break and timeout machine
	always_comb begin
		brk_limit = quad_speed_diag ? `TICK_CNT_W'(`BRK_TICKS_QUAD) : `TICK_CNT_W'(`BRK_TICKS);
		nxt_tx_state = tx_state_ff;
		nxt_brk_cnt = brk_cnt_ff;
		if (!running) begin
			nxt_tx_state = vpw_cfg_pkg::TXS_IDLE; // [RULE8] [RULE12]
			nxt_brk_cnt = '0;
		end else begin
			case (tx_state_ff)
			vpw_cfg_pkg::TXS_IDLE: begin
				nxt_brk_cnt = '0;
				if (tto_trip) begin
					nxt_tx_state = vpw_cfg_pkg::TXS_TIMEOUT;
				end else if (break_req) begin
					nxt_tx_state = vpw_cfg_pkg::TXS_BREAK;
				end
			end
			vpw_cfg_pkg::TXS_BREAK: begin
				if (tto_trip) begin
					nxt_tx_state = vpw_cfg_pkg::TXS_TIMEOUT;
				end else if (brk_cnt_ff >= brk_limit) begin
					// nominal break length kept in quad mode [RULE1]
					nxt_tx_state = vpw_cfg_pkg::TXS_IDLE;
				end else if (tk.us_tick) begin
					nxt_brk_cnt = brk_cnt_ff + `TICK_CNT_W'(1);
				end
			end
			vpw_cfg_pkg::TXS_TIMEOUT: begin
				// stays until enable is cleared [RULE1]
				nxt_tx_state = vpw_cfg_pkg::TXS_TIMEOUT;
			end
			default: begin
				nxt_tx_state = vpw_cfg_pkg::TXS_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			tx_state_ff <= vpw_cfg_pkg::TXS_IDLE;
			brk_cnt_ff <= '0;
		end else begin
			tx_state_ff <= nxt_tx_state;
			brk_cnt_ff <= nxt_brk_cnt;
		end
	end

	assign break_active = (tx_state_ff == vpw_cfg_pkg::TXS_BREAK);
	assign tx_timeout = (tx_state_ff == vpw_cfg_pkg::TXS_TIMEOUT);
	// passive when disabled, frozen or timed out [RULE8]
	assign bus_tx_out = running & ~tx_timeout & (break_active | engine_tx_level);

	// frame length check and queue abort
	always_comb begin
		nxt_frame_cnt = frame_cnt_ff;
		nxt_ifd = ifd_ff;
		// falling enable aborts queued requests [RULE9]
		nxt_queue_abort = block_enable & ~nxt_block_control[`CTL_ENABLE_BIT];
		if (!running) begin
			nxt_frame_cnt = '0;
			nxt_ifd = 1'b0;
		end else begin
			if (rx_eof_min) begin
				nxt_ifd = 1'b0;
				nxt_frame_cnt = '0;
			end
			if (rx_sof) begin
				nxt_frame_cnt = '0;
			end else if (rx_byte_done && frame_cnt_ff < `FRAME_CNT_W'(`MAX_FRAME_BYTES)) begin
				nxt_frame_cnt = frame_cnt_ff + `FRAME_CNT_W'(1);
			end
			// a bit past byte twelve marks the frame invalid; set beats clear [RULE14]
			if (!length_check_off && rx_bit && !rx_sof &&
				frame_cnt_ff == `FRAME_CNT_W'(`MAX_FRAME_BYTES)) begin // [RULE15]
				nxt_ifd = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			frame_cnt_ff <= '0;
			ifd_ff <= 1'b0;
			queue_abort_ff <= 1'b0;
		end else begin
			frame_cnt_ff <= nxt_frame_cnt;
			ifd_ff <= nxt_ifd;
			queue_abort_ff <= nxt_queue_abort;
		end
	end

	assign invalid_frame_flag = ifd_ff; // [RULE14]
	assign rx_sleep = ifd_ff; // [RULE14]
	assign queue_abort = queue_abort_ff | ~running; // [RULE9]
endmodule

// ==== hw/vpw_cfg_defines.svh ====
`ifndef VPW_CFG_DEFINES_SVH
`define VPW_CFG_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_PRESCALE_SELECT 8'hf4
`define IDX_BLOCK_CONTROL 8'hf5
`define IDX_NODE_PHYSICAL_ADDRESS 8'hf6
`define ADDR_W 12

`define RST_PRESCALE_SELECT 8'h00
`define RST_BLOCK_CONTROL 8'h40
`define RST_NODE_PHYSICAL_ADDRESS 8'h00

// prescale_select fields
`define PS_QUAD_BIT 7
`define PS_DIV_HI 5
`define PS_DIV_LO 0
`define PS_WRITE_MASK 8'hbf

// block_control fields
`define CTL_ENABLE_BIT 7
`define CTL_FREEZE_BIT 6
`define CTL_LENCHK_OFF_BIT 5
`define CTL_DELAY_HI 4
`define CTL_DELAY_LO 0

// timing, in microseconds of the prescaled tick
`define BRK_US 300
`define TTO_US 1000
`define QUAD_FACTOR 4
`define BRK_TICKS (`BRK_US)
`define BRK_TICKS_QUAD (`BRK_US * `QUAD_FACTOR)
`define TTO_TICKS (`TTO_US)
`define TTO_TICKS_QUAD (`TTO_US * `QUAD_FACTOR)
`define TICK_CNT_W 12

`define MAX_FRAME_BYTES 12
`define FRAME_CNT_W 5

`endif

// ==== hw/vpw_cfg_pkg.sv ====
package vpw_cfg_pkg;
	typedef enum logic [2:0] {
		TXS_IDLE = 3'b001,
		TXS_BREAK = 3'b010,
		TXS_TIMEOUT = 3'b100
	} tx_state_t;
endpackage

// ==== hw/tick_if.sv ====
`timescale 1ns/10ps
interface tick_if;
	logic us_tick;
	logic quad;
	logic restart;
	modport src (output us_tick, input quad, input restart);
	modport dst (input us_tick, input quad, input restart);
endinterface

// ==== hw/us_prescaler.sv ====
`timescale 1ns/10ps
`include "vpw_cfg_defines.svh"
module us_prescaler (
	input wire logic clk,
	input wire logic srst,
	input wire logic [5:0] div_sel,
	tick_if.src tk
);
	logic [5:0] cnt_ff;
	logic [5:0] nxt_cnt;
	logic tick_ff;
	logic nxt_tick;

	// divide by div_sel+1 for one tick per microsecond
	always_comb begin
		nxt_cnt = cnt_ff + 6'h01;
		nxt_tick = 1'b0;
		if (tk.restart) begin
			nxt_cnt = 6'h00;
		end else if (cnt_ff >= div_sel) begin
			nxt_cnt = 6'h00;
			nxt_tick = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_ff <= 6'h00;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign tk.us_tick = tick_ff;
endmodule

// ==== hw/tx_timeout_guard.sv ====
`timescale 1ns/10ps
`include "vpw_cfg_defines.svh"
module tx_timeout_guard (
	input wire logic clk,
	input wire logic srst,
	input wire logic active,
	tick_if.dst tk,
	output logic tripped
);
	logic [`TICK_CNT_W-1:0] cnt_ff;
	logic [`TICK_CNT_W-1:0] nxt_cnt;
	logic [`TICK_CNT_W-1:0] limit;

	// quad mode: count four times as many ticks; the tick rate stays set by the divider alone, which software adjusts
	always_comb begin
		limit = tk.quad ? `TICK_CNT_W'(`TTO_TICKS_QUAD) : `TICK_CNT_W'(`TTO_TICKS);
		nxt_cnt = cnt_ff;
		if (!active || tk.restart) begin
			nxt_cnt = '0;
		end else if (tk.us_tick && cnt_ff < limit) begin
			nxt_cnt = cnt_ff + `TICK_CNT_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign tripped = (cnt_ff >= limit);
endmodule

// ==== tb/vpw_xcvr_model.sv ====
`timescale 1ns/10ps
module vpw_xcvr_model #(
	parameter int DLY = 3
) (
	input wire logic clk,
	input wire logic tx,
	output logic rx
);
	// bus idles passive, so the inverted echo starts high
	logic [7:0] pipe = 8'hff;
	always @(posedge clk) begin
		pipe <= {pipe[6:0], ~tx};
	end
	assign rx = pipe[DLY];
endmodule

// ==== tb/vpw_cfg_chk.sv ====
`timescale 1ns/10ps
`include "vpw_cfg_defines.svh"
module vpw_cfg_chk (
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic bus_tx_out,
	input wire logic break_req,
	input wire logic rx_bit,
	input wire logic rx_eof_min,
	input wire logic rx_filtered,
	input wire logic status_hold,
	input wire logic engine_reset,
	input wire logic queue_abort,
	input wire logic invalid_frame_flag,
	input wire logic rx_sleep,
	input wire logic tx_timeout,
	input wire logic break_active,
	input wire logic [4:0] loop_delay_sel
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic acc;
	logic hit;
	assign acc = psel && penable;
	assign hit = paddr == 12'h3d0 || paddr == 12'h3d4 || paddr == 12'h3d8;
	a_frozen_quiet: assert property (
		status_hold |-> !bus_tx_out && !rx_filtered && queue_abort)
		else $error("active while frozen");
	a_freeze_restart: assert property (status_hold |-> engine_reset)
		else $error("engines run while frozen");
	a_bad_addr: assert property (acc && !hit |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_good_addr: assert property (
		acc && hit |-> pready && !pslverr && prdata[31:8] == 24'h0)
		else $error("mapped access wrong");
	a_brk_start: assert property (
		break_req && !queue_abort && !break_active && !tx_timeout |=> break_active)
		else $error("break not started");
	a_brk_drive: assert property (
		break_active && !queue_abort && !tx_timeout |-> bus_tx_out)
		else $error("break not driven");
	a_tto_silent: assert property (tx_timeout |-> !bus_tx_out)
		else $error("output after timeout");
	a_sleep_flag: assert property (invalid_frame_flag == rx_sleep)
		else $error("sleep differs from flag");
	a_eof_clear: assert property (rx_eof_min && !rx_bit |=> !invalid_frame_flag)
		else $error("flag kept after end of frame");
	a_delay_hold: assert property (
		!(acc && pwrite && paddr == 12'h3d4) |=> $stable(loop_delay_sel))
		else $error("delay field changed without write");
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
	logic clk = 0;
	logic srst = 1;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, bus_rx_in, bus_tx_out, rx_filtered, us_tick;
	logic engine_reset, status_hold, queue_abort, invalid_frame_flag, rx_sleep;
	logic tx_timeout, break_active, quad_speed_diag;
	logic [4:0] loop_delay_sel;
	logic [7:0] ifr_address_byte;
	logic engine_tx_level = 0;
	logic break_req = 0;
	logic [3:0] rxp = 4'h0;
	wire rx_sof, rx_bit, rx_byte_done, rx_eof_min;
	int fails = 0;
	int comparisons = 0;
	int cyc = 0;
	int c;
	assign {rx_sof, rx_bit, rx_byte_done, rx_eof_min} = rxp;
	vpw_bus_config_registers dut (.clk, .srst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .bus_rx_in, .bus_tx_out, .engine_tx_level,
		.break_req, .rx_sof, .rx_bit, .rx_byte_done, .rx_eof_min, .rx_filtered, .us_tick,
		.engine_reset, .status_hold, .queue_abort, .invalid_frame_flag, .rx_sleep,
		.tx_timeout, .break_active, .loop_delay_sel, .ifr_address_byte, .quad_speed_diag);
	vpw_xcvr_model xcvr (.clk(clk), .tx(bus_tx_out), .rx(bus_rx_in));
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			print_verdict();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task print_verdict;
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int k;
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50)
			fails++;
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rdchk(input logic [11:0] a, input logic [7:0] e);
		apb(0, a, 8'h0);
		chk(rd, {24'h0, e});
	endtask
	task rxpulse(input logic [3:0] v);
		@(posedge clk);
		rxp <= v;
		@(posedge clk);
		rxp <= 4'h0;
	endtask
	// break length (0) or timeout wait (1), capped so a stuck flag cannot hang
	task count_while(input logic which);
		c = 0;
		@(negedge clk);
		while ((which ? tx_timeout !== 1'b1 : break_active === 1'b1) && c < 5000) begin
			c++;
			@(negedge clk);
		end
		// hand back on a rising edge so the caller drives inputs there
		@(posedge clk);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		srst <= 0;
		rdchk(12'h3d0, 8'h00);
		rdchk(12'h3d4, 8'h40);
		rdchk(12'h3d8, 8'h00);
		apb(0, 12'h3dc, 8'h0);
		chk(err, 1);
		apb(1, 12'h3d0, 8'hff);
		rdchk(12'h3d0, 8'hbf);
		chk(quad_speed_diag, 1);
		// tick is held in restart while frozen, so freeze goes first
		apb(1, 12'h3d4, 8'h00); // freeze cleared alone, enable later
		apb(1, 12'h3d0, 8'h18); // divider set while still disabled
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (us_tick !== 1'b1 && c < 99);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (us_tick !== 1'b1 && c < 99);
		chk(32'(c), 32'd25);
		apb(1, 12'h3d4, 8'h9f);
		rdchk(12'h3d4, 8'h9f);
		chk(loop_delay_sel, 5'h1f);
		chk({status_hold, queue_abort}, 2'h0);
		repeat (6) @(negedge clk);
		chk(rx_filtered, 1);
		apb(1, 12'h3d4, 8'h1f);
		engine_tx_level <= 1;
		repeat (2) @(negedge clk);
		chk({queue_abort, rx_filtered, bus_tx_out}, 3'h4);
		engine_tx_level <= 0;
		apb(1, 12'h3d4, 8'hc0);
		rdchk(12'h3d4, 8'h40);
		apb(1, 12'h3d4, 8'h80);
		rdchk(12'h3d4, 8'h00);
		apb(1, 12'h3d8, 8'ha5);
		rdchk(12'h3d8, 8'ha5);
		chk(ifr_address_byte, 8'ha5);
		for (int q = 0; q < 2; q++) begin
			apb(1, 12'h3d0, q ? 8'h80 : 8'h00); // divider and mode together
			apb(1, 12'h3d4, 8'h80);
			@(posedge clk);
			break_req <= 1;
			@(posedge clk);
			break_req <= 0;
			count_while(0);
			chk(c >= (q ? 1198 : 298) && c <= (q ? 1202 : 302), 1);
			engine_tx_level <= 1;
			count_while(1);
			chk(c >= (q ? 3998 : 998) && c <= (q ? 4003 : 1003), 1);
			chk(bus_tx_out, 0);
			engine_tx_level <= 0;
			apb(1, 12'h3d4, 8'h00);
			// state machine drops to idle one edge after the write lands
			repeat (2) @(negedge clk);
			chk(tx_timeout, 0);
		end
		for (int f = 0; f < 2; f++) begin
			apb(1, 12'h3d4, f ? 8'ha0 : 8'h80);
			rxpulse(4'h8);
			repeat (12) rxpulse(4'h2);
			chk(invalid_frame_flag, 0);
			rxpulse(4'h4);
			@(negedge clk);
			chk(invalid_frame_flag, f ? 1'b0 : 1'b1);
			rxpulse(4'h1);
			@(negedge clk);
			chk(invalid_frame_flag, 0);
		end
		apb(1, 12'h3d4, 8'h40);
		@(negedge clk);
		chk({status_hold, engine_reset}, 2'h3);
		print_verdict();
	end
endmodule
bind vpw_bus_config_registers vpw_cfg_chk chk_i (.clk, .srst, .psel, .penable, .pwrite,
	.paddr, .prdata, .pready, .pslverr, .bus_tx_out, .break_req, .rx_bit, .rx_eof_min,
	.rx_filtered, .status_hold, .engine_reset, .queue_abort, .invalid_frame_flag,
	.rx_sleep, .tx_timeout, .break_active, .loop_delay_sel);
